// >>> logic/tcc_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_timer
	import tcc_pkg::*;
#(
	parameter int CNT_W = `TCC_CNT_W
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic fast_osc_tick_in,
	input wire logic slow_osc_trigger_in,
	input wire logic capture_pulse_input_in,
	input wire tcc_ctrl_a_t timer_control_a_in,
	input wire tcc_ctrl_b_t timer_control_b_in,
	input wire tcc_wave_ctrl_t waveform_output_control_in,
	input wire logic [5:0] port_data_in,
	input wire logic [5:0] port_fixed_level_in,
	input wire logic timer_count_wr_in,
	input wire logic cmp0_wr_in,
	input wire logic cmp1_wr_in,
	input wire logic [CNT_W-1:0] wr_data_in,
	output logic [CNT_W-1:0] timer_count_out,
	output logic [CNT_W-1:0] capture_or_compare0_value_out,
	output logic [CNT_W-1:0] compare1_value_out,
	output logic [5:0] compare_waveform_out,
	output tcc_irq_t irq_out
);
	initial begin
		if (CNT_W != 16) $error("tcc_timer: CNT_W must be 16");
	end

	logic tick8;
	logic tick32;
	logic filt_level;
	tcc_divider #(.DIV(`TCC_DIV8)) u_div8 (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.tick_out(tick8)
	);
	tcc_divider #(.DIV(`TCC_DIV32)) u_div32 (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.tick_out(tick32)
	);

	tcc_ctrl_a_t ca;
	tcc_ctrl_b_t cb;
	tcc_wave_ctrl_t cw;
	assign ca = timer_control_a_in;
	assign cb = timer_control_b_in;
	assign cw = waveform_output_control_in;

	logic cnt_tick;
	logic filt_sample;
	always_comb begin
		unique case (ca.count_src)
			TCC_SRC_F1: cnt_tick = 1'b1;
			TCC_SRC_F8: cnt_tick = tick8;
			TCC_SRC_F32: cnt_tick = tick32;
			TCC_SRC_FAST: cnt_tick = fast_osc_tick_in;
		endcase
		unique case (cb.filter_sample_sel)
			2'h1: filt_sample = 1'b1;
			2'h2: filt_sample = tick8;
			2'h3: filt_sample = tick32;
			default: filt_sample = 1'b0;
		endcase
	end

	tcc_filter u_filt (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.raw_in(capture_pulse_input_in),
		.sample_in(filt_sample),
		.bypass_in(cb.filter_sample_sel == 2'h0),
		.level_out(filt_level)
	);

	// trigger edge detection; the edge is held until the next count tick
	logic trig;
	logic trig_d;
	logic pend;
	logic next_pend;
	logic edge_hit;
	assign trig = ca.capture_trigger_sel ? slow_osc_trigger_in : filt_level;
	always_comb begin
		unique case (ca.capture_edge_sel)
			TCC_EDGE_RISE: edge_hit = trig & ~trig_d;
			TCC_EDGE_FALL: edge_hit = ~trig & trig_d;
			TCC_EDGE_BOTH: edge_hit = trig ^ trig_d;
			TCC_EDGE_RSVD: edge_hit = 1'b0;
		endcase
	end

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] cmp0_buf;
	logic [CNT_W-1:0] next_cmp0_buf;
	logic [CNT_W-1:0] cmp1_buf;
	logic [CNT_W-1:0] next_cmp1_buf;
	logic [CNT_W-1:0] cmp0;
	logic [CNT_W-1:0] next_cmp0;
	logic [CNT_W-1:0] cmp1;
	logic [CNT_W-1:0] next_cmp1;
	logic [CNT_W-1:0] cap;
	logic [CNT_W-1:0] next_cap;
	logic wave0;
	logic next_wave0;
	logic wave1;
	logic next_wave1;
	tcc_irq_t irq;
	tcc_irq_t next_irq;
	logic mode_cmp;
	logic adv;
	logic ovf;
	logic m0;
	logic m1;
	assign mode_cmp = cb.compare_mode_sel;
	assign adv = ca.count_run & cnt_tick;
	assign ovf = adv & (cnt == '1);
	assign m0 = adv & mode_cmp & (cnt == cmp0);
	assign m1 = adv & mode_cmp & (cnt == cmp1);

	always_comb begin
		next_cnt = cnt;
		next_cap = cap;
		next_pend = pend;
		next_cmp0_buf = cmp0_buf;
		next_cmp1_buf = cmp1_buf;
		next_cmp0 = cmp0;
		next_cmp1 = cmp1;
		next_wave0 = wave0;
		next_wave1 = wave1;
		next_irq = '0;
		// counter write strobe has no path into next_cnt in either mode
		if (!ca.count_run) begin
			next_cnt = '0;
		end else if (adv) begin
			if (m1 && cb.reload_on_match1) next_cnt = '0;
			else next_cnt = cnt + CNT_W'(1);
		end
		if (!mode_cmp) begin
			// capture register stays write-protected here
			if (pend && cnt_tick) begin
				next_cap = cnt;
				next_irq.capture = 1'b1;
				next_pend = 1'b0;
			end
			// new edge wins over the clear, so back-to-back edges are not lost
			if (edge_hit && ca.count_run) next_pend = 1'b1;
		end else begin
			next_pend = 1'b0;
			if (cmp0_wr_in) next_cmp0_buf = wr_data_in;
			if (cmp1_wr_in) next_cmp1_buf = wr_data_in;
			if (!ca.count_run) begin
				if (cmp0_wr_in) next_cmp0 = wr_data_in;
				if (cmp1_wr_in) next_cmp1 = wr_data_in;
			end else if ((cb.reload_on_match1 && m1) || (!cb.reload_on_match1 && ovf)) begin
				next_cmp0 = next_cmp0_buf;
				next_cmp1 = next_cmp1_buf;
			end
			next_irq.compare0 = m0;
			next_irq.compare1 = m1;
			if (m0) next_wave0 = act(cb.match0_action, wave0);
			if (m1) next_wave1 = act(cb.match1_action, wave1);
		end
		next_irq.overflow = ovf;
	end

	function automatic logic act(input tcc_act_t a, input logic cur);
		unique case (a)
			TCC_ACT_KEEP: act = cur;
			TCC_ACT_TOGGLE: act = ~cur;
			TCC_ACT_LOW: act = 1'b0;
			TCC_ACT_HIGH: act = 1'b1;
		endcase
	endfunction : act

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cnt <= `TCC_CNT_RESET;
			cap <= `TCC_CMP0_RESET;
			cmp0_buf <= `TCC_CMP0_RESET;
			cmp1_buf <= `TCC_CMP1_RESET;
			cmp0 <= `TCC_CMP0_RESET;
			cmp1 <= `TCC_CMP1_RESET;
			pend <= 1'b0;
			trig_d <= 1'b0;
			wave0 <= 1'b0;
			wave1 <= 1'b0;
			irq <= '0;
		end else begin
			cnt <= next_cnt;
			cap <= next_cap;
			cmp0_buf <= next_cmp0_buf;
			cmp1_buf <= next_cmp1_buf;
			cmp0 <= next_cmp0;
			cmp1 <= next_cmp1;
			pend <= next_pend;
			trig_d <= trig;
			wave0 <= next_wave0;
			wave1 <= next_wave1;
			irq <= next_irq;
		end
	end

	// output unit: invert per group, gate per enable and compare mode, then port data picks wave or fixed level
	logic [5:0] wave_raw;
	logic [5:0] next_wave_pins;
	logic [5:0] wave_pins;
	always_comb begin
		wave_raw = {{3{wave1 ^ cw.group1_invert}}, {3{wave0 ^ cw.group0_invert}}};
		for (int i = 0; i < `TCC_WAVES; i++) begin
			if (port_data_in[i] && mode_cmp && cw.wave_out_enable[i]) begin
				next_wave_pins[i] = wave_raw[i];
			end else begin
				next_wave_pins[i] = port_fixed_level_in[i];
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) wave_pins <= '0;
		else wave_pins <= next_wave_pins;
	end

	assign timer_count_out = cnt;
	assign capture_or_compare0_value_out = mode_cmp ? cmp0_buf : cap;
	assign compare1_value_out = cmp1_buf;
	assign compare_waveform_out = wave_pins;
	assign irq_out = irq;

	property p_stop_clears;
		@(posedge sys_clk_in) disable iff (rst_in)
		!ca.count_run |=> (cnt == '0);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("counter not cleared when stopped");

	property p_ovf_irq;
		@(posedge sys_clk_in) disable iff (rst_in)
		(adv && cnt == 16'hFFFF && !(m1 && cb.reload_on_match1)) |=> (irq.overflow && cnt == '0);
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow missing irq or wrap");

	property p_count_up;
		@(posedge sys_clk_in) disable iff (rst_in)
		(adv && !m1 && cnt != 16'hFFFF) |=> (cnt == $past(cnt) + 16'h0001);
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not increment");

	property p_reload;
		@(posedge sys_clk_in) disable iff (rst_in)
		(m1 && cb.reload_on_match1) |=> (cnt == '0 && irq.compare1);
	endproperty
	a_reload: assert property (p_reload) else $error("reload on match 1 failed");

	property p_capture;
		@(posedge sys_clk_in) disable iff (rst_in)
		(!mode_cmp && pend && cnt_tick) |=> (cap == $past(cnt) && irq.capture);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value or irq wrong");

	property p_cap_lag;
		@(posedge sys_clk_in) disable iff (rst_in)
		(!mode_cmp && edge_hit && ca.count_run && ca.count_src == TCC_SRC_F1) |=> ##1 irq.capture;
	endproperty
	a_cap_lag: assert property (p_cap_lag) else $error("capture irq too late");

	property p_match0;
		@(posedge sys_clk_in) disable iff (rst_in)
		(mode_cmp && adv && cnt == cmp0) |=> irq.compare0;
	endproperty
	a_match0: assert property (p_match0) else $error("compare 0 irq missing");

	property p_stopped_load;
		@(posedge sys_clk_in) disable iff (rst_in)
		(mode_cmp && !ca.count_run && cmp1_wr_in) |=> (cmp1 == $past(wr_data_in));
	endproperty
	a_stopped_load: assert property (p_stopped_load) else $error("stopped compare load failed");

	property p_gate;
		@(posedge sys_clk_in) disable iff (rst_in)
		(!cw.wave_out_enable[0]) |=> (compare_waveform_out[0] == $past(port_fixed_level_in[0]));
	endproperty
	a_gate: assert property (p_gate) else $error("disabled output not at fixed level");

	property p_cnt_wr_ignored;
		@(posedge sys_clk_in) disable iff (rst_in)
		(timer_count_wr_in && adv && !m1 && cnt != 16'hFFFF) |=> (cnt == $past(cnt) + 16'h0001);
	endproperty
	a_cnt_wr_ignored: assert property (p_cnt_wr_ignored) else $error("counter write was not ignored");
endmodule : tcc_timer
`default_nettype wire

// >>> common/tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_CNT_W 16
`define TCC_CNT_RESET 16'h0000
`define TCC_CMP0_RESET 16'h0000
`define TCC_CMP1_RESET 16'hFFFF
`define TCC_DIV8 8
`define TCC_DIV32 32
`define TCC_FILT_LEN 3
`define TCC_WAVES 6
`endif

// >>> common/tcc_pkg.sv
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_SRC_F1,
		TCC_SRC_F8,
		TCC_SRC_F32,
		TCC_SRC_FAST
	} tcc_src_t;
	typedef enum logic [1:0] {
		TCC_EDGE_RISE,
		TCC_EDGE_FALL,
		TCC_EDGE_BOTH,
		TCC_EDGE_RSVD
	} tcc_edge_t;
	typedef enum logic [1:0] {
		TCC_ACT_KEEP,
		TCC_ACT_TOGGLE,
		TCC_ACT_LOW,
		TCC_ACT_HIGH
	} tcc_act_t;
	typedef struct packed {
		logic count_run;
		tcc_src_t count_src;
		tcc_edge_t capture_edge_sel;
		logic capture_trigger_sel;
	} tcc_ctrl_a_t;
	typedef struct packed {
		logic [1:0] filter_sample_sel;
		logic reload_on_match1;
		logic compare_mode_sel;
		tcc_act_t match0_action;
		tcc_act_t match1_action;
	} tcc_ctrl_b_t;
	typedef struct packed {
		logic [5:0] wave_out_enable;
		logic group0_invert;
		logic group1_invert;
	} tcc_wave_ctrl_t;
	typedef struct packed {
		logic capture;
		logic overflow;
		logic compare0;
		logic compare1;
	} tcc_irq_t;
endpackage : tcc_pkg

// >>> logic/tcc_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_divider
	import tcc_pkg::*;
#(
	parameter int DIV = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	output logic tick_out
);
	initial begin
		if (DIV < 2) $error("tcc_divider: DIV must be at least 2");
	end
	localparam int W = $clog2(DIV);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	always_comb begin
		next_cnt = (cnt == W'(DIV - 1)) ? '0 : cnt + W'(1);
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) cnt <= '0;
		else cnt <= next_cnt;
	end
	assign tick_out = (cnt == W'(DIV - 1));
endmodule : tcc_divider
`default_nettype wire

// >>> logic/tcc_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_filter
	import tcc_pkg::*;
#(
	parameter int LEN = `TCC_FILT_LEN
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic raw_in,
	input wire logic sample_in,
	input wire logic bypass_in,
	output logic level_out
);
	initial begin
		if (LEN < 2) $error("tcc_filter: LEN must be at least 2");
	end
	logic [LEN-1:0] hist;
	logic [LEN-1:0] next_hist;
	logic level;
	logic next_level;
	// unless bypassed, level moves only after LEN equal samples, rejecting short glitches
	always_comb begin
		next_hist = hist;
		next_level = level;
		if (bypass_in) begin
			next_hist = {LEN{raw_in}};
			next_level = raw_in;
		end else if (sample_in) begin
			next_hist = {hist[LEN-2:0], raw_in};
			if (&next_hist) next_level = 1'b1;
			else if (~|next_hist) next_level = 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			hist <= '0;
			level <= 1'b0;
		end else begin
			hist <= next_hist;
			level <= next_level;
		end
	end
	assign level_out = level;
endmodule : tcc_filter
`default_nettype wire

// >>> verif/tcc_pulse_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_pulse_model #(
	parameter int FAST_DIV = 4
) (
	input wire logic sys_clk_in,
	output logic pulse_out,
	output logic slow_out,
	output logic fast_tick_out
);
	int fcnt;
	initial begin
		pulse_out = 1'b0;
		slow_out = 1'b0;
		fast_tick_out = 1'b0;
		fcnt = 0;
	end
	// fast oscillator free-runs, so its tick is unrelated to run start
	always @(posedge sys_clk_in) begin
		#1;
		fcnt = (fcnt + 1) % FAST_DIV;
		fast_tick_out = (fcnt == 0);
	end
	task automatic pulse(input int len, input logic slow);
		if (slow) begin
			slow_out = 1'b1;
		end else begin
			pulse_out = 1'b1;
		end
		repeat (len) @(posedge sys_clk_in);
		#1;
		slow_out = 1'b0;
		pulse_out = 1'b0;
	endtask : pulse
endmodule : tcc_pulse_model
`default_nettype wire

// >>> verif/timer_capture_compare_16bit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module timer_capture_compare_16bit_tb_top
	import tcc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cnt_wr = 1'b0;
	logic w0 = 1'b0;
	logic w1 = 1'b0;
	logic [15:0] wd = 16'h0000;
	logic [5:0] pd = 6'h00;
	logic [5:0] fx = 6'h00;
	tcc_ctrl_a_t ca = '0;
	tcc_ctrl_b_t cb = '0;
	tcc_wave_ctrl_t wc = '0;
	logic fast_t, slow_t, pin;
	logic [15:0] cnt, cv0, cv1, a;
	logic [5:0] wave;
	tcc_irq_t irq;
	logic [31:0] r;
	logic [15:0] c0_at = 16'h0000;
	int err_total = 0, check_count = 0, seed = 43725;
	int n_cap = 0, n_ovf = 0, n_c0 = 0, n_c1 = 0;
	logic [15:0] rate_d [4] = '{16'h0040, 16'h0008, 16'h0002, 16'h0010};
	logic [15:0] cap_e [4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0000};

	tcc_timer i_dut (.sys_clk_in(clk), .rst_in(rst), .fast_osc_tick_in(fast_t), .slow_osc_trigger_in(slow_t),
		.capture_pulse_input_in(pin), .timer_control_a_in(ca), .timer_control_b_in(cb),
		.waveform_output_control_in(wc), .port_data_in(pd), .port_fixed_level_in(fx),
		.timer_count_wr_in(cnt_wr), .cmp0_wr_in(w0), .cmp1_wr_in(w1), .wr_data_in(wd),
		.timer_count_out(cnt), .capture_or_compare0_value_out(cv0), .compare1_value_out(cv1),
		.compare_waveform_out(wave), .irq_out(irq));
	tcc_pulse_model mdl (.sys_clk_in(clk), .pulse_out(pin), .slow_out(slow_t), .fast_tick_out(fast_t));

	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (irq.capture === 1'b1) n_cap++;
		if (irq.overflow === 1'b1) n_ovf++;
		if (irq.compare1 === 1'b1) n_c1++;
		if (irq.compare0 === 1'b1) begin
			n_c0++;
			c0_at = cnt;
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic run(input logic go);
		ca.count_run = go;
		cyc(3);
	endtask : run
	// sel 0 compare 0, 1 compare 1, 2 counter; always whole 16-bit words
	task automatic wr(input logic [1:0] sel, input logic [15:0] d);
		wd = d;
		w0 = (sel == 2'h0);
		w1 = (sel == 2'h1);
		cnt_wr = (sel == 2'h2);
		cyc(1);
		w0 = 1'b0;
		w1 = 1'b0;
		cnt_wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic cap(input int len, input logic slow, input logic [15:0] e);
		n_cap = 0;
		a = cnt;
		mdl.pulse(len, slow);
		cyc(130);
		check(n_cap[15:0], e);
	endtask : cap
	function automatic logic [5:0] ew(input logic s0, input logic s1);
		logic [5:0] w, g;
		w = {{3{s1 ^ wc.group1_invert}}, {3{s0 ^ wc.group0_invert}}};
		g = wc.wave_out_enable & pd;
		return (w & g) | (fx & ~g);
	endfunction : ew

	initial begin
		#4000000;
		err_total++;
		final_report();
	end
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		check(cnt, 16'h0000);
		check(cv0, 16'h0000);
		check(cv1, 16'hFFFF);
		check({10'h000, wave}, 16'h0000);
		check({12'h000, irq}, 16'h0000);
		$display("reset test done");
		for (int s = 0; s < 4; s++) begin
			ca.count_src = tcc_src_t'(s);
			run(1);
			a = cnt;
			cyc(64);
			check(cnt - a, rate_d[s]);
			run(0);
			check(cnt, 16'h0000);
		end
		wr(2'h2, 16'h1234);
		check(cnt, 16'h0000);
		$display("count source test done");
		ca.count_src = TCC_SRC_F1;
		for (int e = 0; e < 4; e++) begin
			run(0);
			ca.capture_edge_sel = tcc_edge_t'(e);
			run(1);
			cap(10, 1'b0, cap_e[e]);
			if (e == 0) check({15'h0000, (cv0 - a) <= 16'h0020}, 16'h0001);
		end
		run(0);
		ca.capture_edge_sel = TCC_EDGE_RISE;
		for (int f = 1; f < 4; f++) begin
			cb.filter_sample_sel = f[1:0];
			run(1);
			cap(1, 1'b0, 16'h0000);
			cap(120, 1'b0, 16'h0001);
			run(0);
		end
		cb.filter_sample_sel = 2'h0;
		ca.capture_trigger_sel = 1'b1;
		run(1);
		cap(10, 1'b1, 16'h0001);
		cap(10, 1'b0, 16'h0000);
		a = cv0;
		wr(2'h0, 16'hABCD);
		check(cv0, a);
		run(0);
		$display("capture test done");
		cb.compare_mode_sel = 1'b1;
		cb.reload_on_match1 = 1'b1;
		cb.match0_action = TCC_ACT_HIGH;
		cb.match1_action = TCC_ACT_LOW;
		wr(2'h0, 16'h0005);
		wr(2'h1, 16'h000A);
		check(cv0, 16'h0005);
		check(cv1, 16'h000A);
		n_c0 = 0;
		n_c1 = 0;
		run(1);
		cyc(100);
		check(n_c0[15:0], 16'h0009);
		check(n_c1[15:0], 16'h0009);
		check({15'h0000, cnt <= 16'h000A}, 16'h0001);
		wr(2'h0, 16'h0003);
		cyc(24);
		check(c0_at, 16'h0004);
		run(0);
		repeat (8) begin
			r = $random(seed);
			pd = r[5:0];
			fx = r[11:6];
			wc = r[19:12];
			cyc(3);
			check({10'h000, wave}, {10'h000, ew(1'b1, 1'b0)});
		end
		pd = 6'h3F;
		wc = '{6'h3F, 1'b0, 1'b1};
		cb.reload_on_match1 = 1'b0;
		for (int k = 0; k < 2; k++) begin
			cb.match0_action = k ? TCC_ACT_LOW : TCC_ACT_TOGGLE;
			cb.match1_action = k ? TCC_ACT_HIGH : TCC_ACT_KEEP;
			run(1);
			cyc(k ? 11 : 5);
			run(0);
			check({10'h000, wave}, {10'h000, ew(1'b0, k[0])});
		end
		$display("compare test done");
		cb.match0_action = TCC_ACT_KEEP;
		cb.match1_action = TCC_ACT_KEEP;
		wr(2'h0, 16'h0002);
		n_c0 = 0;
		n_ovf = 0;
		run(1);
		cyc(97);
		wr(2'h0, 16'h0200);
		check(cv0, 16'h0200);
		a = cnt;
		wr(2'h2, 16'hFFF0);
		check(cnt - a, 16'h0002);
		cyc(64900);
		check(n_c0[15:0], 16'h0001);
		cyc(600);
		check(n_ovf[15:0], 16'h0001);
		check(n_c0[15:0], 16'h0001);
		cyc(500);
		check(n_c0[15:0], 16'h0002);
		check({15'h0000, c0_at > 16'h0200 && c0_at < 16'h0204}, 16'h0001);
		check({15'h0000, cnt < 16'h0400}, 16'h0001);
		$display("overflow test done");
		final_report();
	end
endmodule : timer_capture_compare_16bit_tb_top
`default_nettype wire
